// ---- include/regacc_pkg.sv ----
// Package for the process-image register access block.
// Assumes one 50 MHz clock and a three-byte process image channel.
package regacc_pkg;

    // ==========================================================
    // Control byte layout
    localparam int CTRL_REG_BIT   = 7;
    localparam int CTRL_WRITE_BIT = 6;
    localparam int INDEX_WIDTH    = 6;
    localparam int REG_COUNT      = 64;

    // ==========================================================
    // Register indices
    localparam logic [5:0] IDX_RAW_VALUE    = 6'h00;
    localparam logic [5:0] IDX_DIAG_STATUS  = 6'h06;
    localparam logic [5:0] IDX_HW_VERSION   = 6'h10;
    localparam logic [5:0] IDX_HW_OFFSET    = 6'h11;
    localparam logic [5:0] IDX_HW_GAIN      = 6'h12;
    localparam logic [5:0] IDX_MAKER_OFFSET = 6'h13;
    localparam logic [5:0] IDX_MAKER_SCALE  = 6'h14;
    localparam logic [5:0] IDX_REF_GAIN     = 6'h15;
    localparam logic [5:0] IDX_UNLOCK_CODE  = 6'h1f;
    localparam logic [5:0] IDX_TYPE_LAST    = 6'h2e;

    // ==========================================================
    // Reset values and codes
    localparam logic [15:0] UNLOCK_VALUE       = 16'h1235;
    localparam logic [15:0] RST_HW_VERSION     = 16'h0000;
    localparam logic [15:0] RST_HW_OFFSET      = 16'h0000;
    localparam logic [15:0] RST_HW_GAIN        = 16'h0000;
    localparam logic [15:0] RST_MAKER_OFFSET   = 16'h0000;
    localparam logic [15:0] RST_MAKER_SCALE    = 16'h00a0;
    localparam logic [15:0] RST_REF_GAIN       = 16'h0000;
    localparam logic [15:0] RST_UNLOCK_CODE    = 16'h0000;

    // ==========================================================
    // One logical channel: control or status byte then two data bytes.
    typedef struct packed {
        logic [7:0] data_high;
        logic [7:0] data_low;
        logic [7:0] ctrl;
    } channel_type;

endpackage

// ---- core/process_image_register_access.sv ----
// Register access path of a two-channel input terminal over the process
// image. Assumes the controller presents one output channel per cycle,
// synchronous to clk.
`timescale 1ns/100ps
`default_nettype none

module process_image_register_access (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    // Process image from the controller
    input  wire regacc_pkg::channel_type out_image,
    input  wire logic                  out_valid,
    // Process image back to the controller
    output var  regacc_pkg::channel_type in_image,
    output logic                       in_valid,
    // Measurement side
    input  wire logic [15:0]           raw_value,
    input  wire logic [7:0]            terminal_status,
    input  wire logic [15:0]           process_data,
    input  wire logic                  maker_scaling_enable,
    // Parameters seen by the measurement path
    output logic [15:0]                hw_offset_trim,
    output logic [15:0]                hw_gain_trim,
    output logic [15:0]                maker_offset_eff,
    output logic [15:0]                maker_scale_eff,
    output logic [15:0]                ref_gain,
    output logic                       params_unlocked
);
    import regacc_pkg::*;

    // ==========================================================
    // Reset synchroniser
    // Assertion is immediate; release is retimed so that every register
    // leaves reset on the same edge, never half a cycle apart.
    logic rst_meta_q;
    logic rst_sync_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    wire rst_n = rst_sync_q;

    // ==========================================================
    // Control byte decode
    wire       reg_mode  = out_image.ctrl[CTRL_REG_BIT];
    wire       write_req = out_image.ctrl[CTRL_WRITE_BIT];
    wire [5:0] index     = out_image.ctrl[INDEX_WIDTH-1:0];
    wire [15:0] wdata    = {out_image.data_high, out_image.data_low};
    wire       access    = out_valid && reg_mode;
    wire       do_write  = access && write_req;
    wire       do_read   = access && !write_req;

    // ==========================================================
    // Parameter storage
    logic [15:0] hw_version_q;
    logic [15:0] hw_offset_q;
    logic [15:0] hw_gain_q;
    logic [15:0] maker_offset_q;
    logic [15:0] maker_scale_q;
    logic [15:0] ref_gain_q;
    logic [15:0] code_q;

    wire unlocked    = (code_q == UNLOCK_VALUE);
    // Only parameter writes check the code; the code register itself is open.
    wire param_write = do_write && unlocked;
    wire wr_version  = param_write && (index == IDX_HW_VERSION);
    wire wr_offset   = param_write && (index == IDX_HW_OFFSET);
    wire wr_gain     = param_write && (index == IDX_HW_GAIN);
    wire wr_moffset  = param_write && (index == IDX_MAKER_OFFSET);
    wire wr_mscale   = param_write && (index == IDX_MAKER_SCALE);
    wire wr_refgain  = param_write && (index == IDX_REF_GAIN);
    wire wr_code     = do_write && (index == IDX_UNLOCK_CODE);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hw_version_q   <= RST_HW_VERSION;
            hw_offset_q    <= RST_HW_OFFSET;
            hw_gain_q      <= RST_HW_GAIN;
            maker_offset_q <= RST_MAKER_OFFSET;
            maker_scale_q  <= RST_MAKER_SCALE;
            ref_gain_q     <= RST_REF_GAIN;
            code_q         <= RST_UNLOCK_CODE;
        end else begin
            if (wr_version) hw_version_q <= wdata;
            if (wr_offset)  hw_offset_q <= wdata;
            if (wr_gain)    hw_gain_q <= wdata;
            if (wr_moffset) maker_offset_q <= wdata;
            if (wr_mscale)  maker_scale_q <= wdata;
            if (wr_refgain) ref_gain_q <= wdata;
            if (wr_code)    code_q <= wdata;
        end
    end

    // ==========================================================
    // Read multiplexer
    wire [15:0] code_view = unlocked ? code_q : 16'h0000;
    wire [15:0] diag_word = {8'h00, terminal_status};
    logic [15:0] rdata;
    always_comb begin
        if (index == IDX_RAW_VALUE)          rdata = raw_value;
        else if (index == IDX_DIAG_STATUS)   rdata = diag_word;
        else if (index == IDX_HW_VERSION)    rdata = hw_version_q;
        else if (index == IDX_HW_OFFSET)     rdata = hw_offset_q;
        else if (index == IDX_HW_GAIN)       rdata = hw_gain_q;
        else if (index == IDX_MAKER_OFFSET)  rdata = maker_offset_q;
        else if (index == IDX_MAKER_SCALE)   rdata = maker_scale_q;
        else if (index == IDX_REF_GAIN)      rdata = ref_gain_q;
        else if (index == IDX_UNLOCK_CODE)   rdata = code_view;
        else                                 rdata = 16'h0000;
    end

    // ==========================================================
    // Answer channel: status echoes the control byte on completion.
    channel_type answer;
    always_comb begin
        if (!reg_mode) begin
            answer.ctrl      = out_image.ctrl;
            answer.data_low  = process_data[7:0];
            answer.data_high = process_data[15:8];
        end else if (write_req) begin
            answer.ctrl      = out_image.ctrl;
            answer.data_low  = 8'h00;
            answer.data_high = 8'h00;
        end else begin
            answer.ctrl      = out_image.ctrl;
            answer.data_low  = rdata[7:0];
            answer.data_high = rdata[15:8];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_image <= '0;
            in_valid <= 1'b0;
        end else begin
            in_valid <= out_valid;
            if (out_valid) in_image <= answer;
        end
    end

    // ==========================================================
    // Parameters to the measurement path; maker line applies only when
    // enabled, otherwise identity values so the path needs no extra mux.
    assign hw_offset_trim   = hw_offset_q;
    assign hw_gain_trim     = hw_gain_q;
    assign maker_offset_eff = maker_scaling_enable ? maker_offset_q
                                                   : 16'h0000;
    assign maker_scale_eff  = maker_scaling_enable ? maker_scale_q
                                                   : 16'h0100;
    assign ref_gain         = ref_gain_q;
    assign params_unlocked  = unlocked;

    // ==========================================================
    // Assertion helpers
    // Every stored word in one vector, so a single $stable covers them all.
    wire [95:0]  param_bank = {hw_version_q, hw_offset_q, hw_gain_q,
                               maker_offset_q, maker_scale_q, ref_gain_q};
    wire [111:0] store_bank = {param_bank, code_q};

    // ==========================================================
    // Assertions: code word and write protection
    a_unlock_code: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_code && wdata == UNLOCK_VALUE |=> params_unlocked)
        else $error("code word did not unlock");

    a_relock_code: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_code && wdata != UNLOCK_VALUE |=> !params_unlocked)
        else $error("other value did not relock");

    a_code_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_code |=> code_q == $past(wdata))
        else $error("code word register not written");

    a_code_readback: assert property (
        @(posedge clk) disable iff (!rst_n)
        do_read && index == IDX_UNLOCK_CODE |=>
        {in_image.data_high, in_image.data_low} ==
        ($past(unlocked) ? UNLOCK_VALUE : 16'h0000))
        else $error("code word readback wrong");

    a_locked_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        do_read && index == IDX_UNLOCK_CODE && !unlocked |=>
        {in_image.data_high, in_image.data_low} == 16'h0000)
        else $error("locked code word not read as zero");

    a_locked_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        do_write && !unlocked && index == IDX_MAKER_SCALE |=>
        $stable(maker_scale_q))
        else $error("protected register changed");

    a_locked_params: assert property (
        @(posedge clk) disable iff (!rst_n)
        do_write && !unlocked && index >= IDX_HW_VERSION &&
        index <= IDX_REF_GAIN |=> $stable(param_bank))
        else $error("protected parameter area changed");

    // ==========================================================
    // Assertions: answer channel
    a_status_echo: assert property (
        @(posedge clk) disable iff (!rst_n)
        access |=> in_valid && in_image.ctrl == $past(out_image.ctrl))
        else $error("status byte does not echo control");

    a_answer_pulse: assert property (
        @(posedge clk) disable iff (!rst_n)
        !out_valid |=> !in_valid)
        else $error("answer valid without a request");

    a_answer_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        !out_valid |=> $stable(in_image))
        else $error("answer changed without a request");

    a_write_ack: assert property (
        @(posedge clk) disable iff (!rst_n)
        do_write |=> in_image.data_high == 8'h00 &&
        in_image.data_low == 8'h00)
        else $error("write acknowledge data not zero");

    a_ack_regbit: assert property (
        @(posedge clk) disable iff (!rst_n)
        do_write |=> in_image.ctrl[CTRL_REG_BIT] &&
        in_image.ctrl[INDEX_WIDTH-1:0] == $past(index))
        else $error("write acknowledge lacks index or register bit");

    a_process_pass: assert property (
        @(posedge clk) disable iff (!rst_n)
        out_valid && !reg_mode |=>
        {in_image.data_high, in_image.data_low} == $past(process_data))
        else $error("process data not passed");

    a_no_access: assert property (
        @(posedge clk) disable iff (!rst_n)
        out_valid && !reg_mode |=> $stable(store_bank))
        else $error("process transfer changed a register");

    a_read_nochange: assert property (
        @(posedge clk) disable iff (!rst_n)
        do_read |=> $stable(store_bank))
        else $error("register read changed a register");

    a_raw_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        do_read && index == IDX_RAW_VALUE |=>
        {in_image.data_high, in_image.data_low} == $past(raw_value))
        else $error("raw value readback wrong");

    a_diag_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        do_read && index == IDX_DIAG_STATUS |=>
        {in_image.data_high, in_image.data_low} ==
        {8'h00, $past(terminal_status)})
        else $error("diagnostic readback wrong");

    a_unimpl_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        do_read && index > IDX_TYPE_LAST |=>
        {in_image.data_high, in_image.data_low} == 16'h0000)
        else $error("unimplemented index not zero");

    // ==========================================================
    // Assertions: parameter storage
    a_version_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        do_write && unlocked && index == IDX_HW_VERSION |=>
        hw_version_q == $past(wdata))
        else $error("hardware version not written");

    a_offset_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        do_write && unlocked && index == IDX_HW_OFFSET |=>
        hw_offset_trim == $past(wdata))
        else $error("hardware offset not written");

    a_gain_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        do_write && unlocked && index == IDX_HW_GAIN |=>
        hw_gain_trim == $past(wdata))
        else $error("hardware gain not written");

    a_maker_offset_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        do_write && unlocked && index == IDX_MAKER_OFFSET |=>
        maker_offset_q == $past(wdata))
        else $error("maker offset not written");

    a_maker_scale_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        do_write && unlocked && index == IDX_MAKER_SCALE |=>
        maker_scale_q == $past(wdata))
        else $error("maker scale not written");

    a_ref_gain_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        do_write && unlocked && index == IDX_REF_GAIN |=>
        ref_gain == $past(wdata))
        else $error("reference gain not written");

    a_maker_identity: assert property (
        @(posedge clk) disable iff (!rst_n)
        !maker_scaling_enable |->
        maker_offset_eff == 16'h0000 && maker_scale_eff == 16'h0100)
        else $error("disabled maker line not identity");

    a_maker_pass: assert property (
        @(posedge clk) disable iff (!rst_n)
        maker_scaling_enable |->
        maker_offset_eff == maker_offset_q &&
        maker_scale_eff == maker_scale_q)
        else $error("enabled maker line not applied");

    // ==========================================================
    // Cover points
    c_unlock: cover property (@(posedge clk) disable iff (!rst_n)
        wr_code && wdata == UNLOCK_VALUE);
    c_param_write: cover property (@(posedge clk) disable iff (!rst_n)
        wr_mscale);
    c_locked_write: cover property (@(posedge clk) disable iff (!rst_n)
        do_write && !unlocked && index == IDX_HW_OFFSET);
    c_read: cover property (@(posedge clk) disable iff (!rst_n) do_read);
    c_process: cover property (@(posedge clk) disable iff (!rst_n)
        out_valid && !reg_mode);

endmodule // process_image_register_access

`default_nettype wire

// ---- verification/controller_model.sv ----
// Bus controller model that exchanges process image channels with the block.
// Assumes calls are made just after a rising edge of clk.
`timescale 1ns/100ps
`default_nettype none

module controller_model (
    // Clock
    input  wire logic                    clk,
    // Process image towards the terminal
    output var  regacc_pkg::channel_type out_image,
    output var  logic                    out_valid,
    // Process image from the terminal
    input  wire regacc_pkg::channel_type in_image,
    input  wire logic                    in_valid
);
    import regacc_pkg::*;

    initial begin
        out_image = 24'h000000;
        out_valid = 1'b0;
    end

    // ==========================================================
    // One channel exchange
    // The operation only counts as done once the status echoes the control.
    task automatic access(input logic [7:0] ctrl, input logic [15:0] value,
                          output channel_type answer, output logic done);
        int n;
        out_image = {value, ctrl};
        out_valid = 1'b1;
        @(posedge clk);
        #1;
        out_valid = 1'b0;
        // Released lines must not keep showing the last request.
        out_image = ~out_image;
        done = 1'b0;
        for (n = 0; n < 4 && !done; n++) begin
            if (in_valid === 1'b1 && in_image.ctrl === ctrl) begin
                done = 1'b1;
            end else begin
                @(posedge clk);
                #1;
            end
        end
        answer = in_image;
        // One idle edge keeps a following call from re-raising valid at once.
        @(posedge clk);
        #1;
    endtask
endmodule // controller_model
`default_nettype wire

// ---- verification/process_image_register_access_tb.sv ----
// Self-checking bench for the process-image register access block.
// Assumes the controller model drives the output image channel.
`timescale 1ns/100ps
`default_nettype none

module process_image_register_access_tb;
    import regacc_pkg::*;

    logic        clk;
    logic        reset_n;
    channel_type out_image;
    channel_type in_image;
    logic        out_valid;
    logic        in_valid;
    logic [15:0] raw_value;
    logic [7:0]  terminal_status;
    logic [15:0] process_data;
    logic        maker_scaling_enable;
    logic [15:0] hw_offset_trim;
    logic [15:0] hw_gain_trim;
    logic [15:0] maker_offset_eff;
    logic [15:0] maker_scale_eff;
    logic [15:0] ref_gain;
    logic        params_unlocked;
    int          fails;
    int          checks;
    int          cycles;
    int          i;
    logic [5:0]  idx;

    process_image_register_access dut (.clk(clk), .reset_n(reset_n),
        .out_image(out_image), .out_valid(out_valid), .in_image(in_image),
        .in_valid(in_valid), .raw_value(raw_value),
        .terminal_status(terminal_status), .process_data(process_data),
        .maker_scaling_enable(maker_scaling_enable),
        .hw_offset_trim(hw_offset_trim), .hw_gain_trim(hw_gain_trim),
        .maker_offset_eff(maker_offset_eff),
        .maker_scale_eff(maker_scale_eff), .ref_gain(ref_gain),
        .params_unlocked(params_unlocked));

    controller_model ctl (.clk(clk), .out_image(out_image),
        .out_valid(out_valid), .in_image(in_image), .in_valid(in_valid));

    // ==========================================================
    // Helpers
    task automatic report_and_stop;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic [7:0] ctrl, input logic [15:0] value,
                        input logic [15:0] exp);
        channel_type ans;
        logic        ok;
        ctl.access(ctrl, value, ans, ok);
        check({15'h0000, ok}, 16'h0001);
        check({ans.data_high, ans.data_low}, exp);
    endtask

    task automatic rd(input logic [5:0] a, input logic [15:0] exp);
        xfer({2'b10, a}, 16'h0000, exp);
    endtask

    task automatic wr(input logic [5:0] a, input logic [15:0] value);
        xfer({2'b11, a}, value, 16'h0000);
    endtask

    // ==========================================================
    // Clock, reset and watchdog
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            report_and_stop();
        end
    end

    // ==========================================================
    // Test sequence
    initial begin
        reset_n = 1'b0;
        raw_value = 16'hbeef;
        terminal_status = 8'ha5;
        process_data = 16'h3c5a;
        maker_scaling_enable = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        reset_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        rd(IDX_MAKER_OFFSET, 16'h0000);
        rd(IDX_MAKER_SCALE, 16'h00a0);
        rd(IDX_UNLOCK_CODE, 16'h0000);
        check(maker_scale_eff, 16'h0100);
        rd(IDX_RAW_VALUE, 16'hbeef);
        rd(IDX_DIAG_STATUS, 16'h00a5);
        xfer(8'h55, 16'h7777, 16'h3c5a);
        rd(IDX_REF_GAIN, 16'h0000);
        wr(IDX_HW_OFFSET, 16'h5555);
        rd(IDX_HW_OFFSET, 16'h0000);
        check(hw_offset_trim, 16'h0000);
        wr(IDX_UNLOCK_CODE, 16'h1235);
        check({15'h0000, params_unlocked}, 16'h0001);
        rd(IDX_UNLOCK_CODE, 16'h1235);
        // Each parameter gets a value built from its own index.
        for (i = 0; i < 6; i++) begin
            idx = IDX_HW_VERSION + i[5:0];
            wr(idx, {10'h204, idx});
            rd(idx, {10'h204, idx});
        end
        maker_scaling_enable = 1'b1;
        check(hw_offset_trim, 16'h8111);
        check(hw_gain_trim, 16'h8112);
        check(ref_gain, 16'h8115);
        @(posedge clk);
        #1;
        check(maker_offset_eff, 16'h8113);
        check(maker_scale_eff, 16'h8114);
        // Unlocked now, so a stray process-mode write would really land.
        xfer(8'h55, 16'h7777, 16'h3c5a);
        rd(IDX_REF_GAIN, 16'h8115);
        wr(IDX_RAW_VALUE, 16'h1111);
        rd(IDX_RAW_VALUE, 16'hbeef);
        wr(6'h30, 16'hffff);
        rd(6'h30, 16'h0000);
        rd(6'h3f, 16'h0000);
        wr(IDX_UNLOCK_CODE, 16'h1234);
        check({15'h0000, params_unlocked}, 16'h0000);
        rd(IDX_UNLOCK_CODE, 16'h0000);
        wr(IDX_MAKER_SCALE, 16'h0001);
        rd(IDX_MAKER_SCALE, 16'h8114);
        maker_scaling_enable = 1'b0;
        @(posedge clk);
        #1;
        check(maker_offset_eff, 16'h0000);
        report_and_stop();
    end
endmodule // process_image_register_access_tb
`default_nettype wire
